// ==== hpsr_map.svh ====
`ifndef HPSR_MAP_SVH
`define HPSR_MAP_SVH
// Clock and serial framing
`define HPSR_CLK_HZ 20000000
`define HPSR_CLK_NS 50
`define HPSR_BAUD 19200
`define HPSR_DATA_BITS 8
`define HPSR_BIT_CYCLES (`HPSR_CLK_HZ / `HPSR_BAUD)
// Port idle release: 5 minutes counted in 1 ms ticks
`define HPSR_TICK_NS 1000000
`define HPSR_PRESCALE (`HPSR_TICK_NS / `HPSR_CLK_NS)
`define HPSR_IDLE_MIN 5
`define HPSR_IDLE_TICKS (`HPSR_IDLE_MIN * 60 * 1000)
// Event flag positions
`define HPSR_EV_OPC 0
`define HPSR_EV_QRY 2
`define HPSR_EV_DEV 3
`define HPSR_EV_EXE 4
`define HPSR_EV_CMD 5
`define HPSR_EV_PON 7
`define HPSR_EV_UNUSED_MASK 8'h42
`define HPSR_FLAGS_RST 8'h80
// Summary byte positions
`define HPSR_SB_MAV 4
`define HPSR_SB_ESB 5
`define HPSR_SB_MSS 6
// Bus address
`define HPSR_ADDR_RST 5'h01
`define HPSR_ADDR_MIN 8'h01
`define HPSR_ADDR_MAX 8'h1e
// Response buffer
`define HPSR_FIFO_WIDTH 8
`define HPSR_FIFO_DEPTH 32
`endif

// ==== hpsr_pkg.sv ====
package hpsr_pkg;
  // Host commands after parsing
  typedef enum logic [3:0] {
    HPSR_CMD_NOP = 4'h0,
    HPSR_CMD_RD_FLAGS = 4'h1,
    HPSR_CMD_WR_ENABLE = 4'h2,
    HPSR_CMD_RD_ENABLE = 4'h3,
    HPSR_CMD_WR_MASK = 4'h4,
    HPSR_CMD_RD_MASK = 4'h5,
    HPSR_CMD_RD_SUMMARY = 4'h6,
    HPSR_CMD_CLEAR = 4'h7,
    HPSR_CMD_WR_ADDR = 4'h8,
    HPSR_CMD_RD_ADDR = 4'h9,
    HPSR_CMD_RD_VERSION = 4'ha
  } hpsr_cmd_type;
  // Active host port, one-hot
  typedef enum logic [2:0] {
    HPSR_PORT_NONE = 3'h1,
    HPSR_PORT_SER = 3'h2,
    HPSR_PORT_BUS = 3'h4
  } hpsr_port_type;
endpackage

// ==== hpsr_fifo_if.sv ====
`timescale 1ns/10ps
`default_nettype none
// Response buffer hookup
interface hpsr_fifo_if #(parameter int WIDTH = 8);
  logic [WIDTH-1:0] wdata; // Fill side data
  logic wvalid;
  logic wready;
  logic [WIDTH-1:0] rdata; // Drain side data
  logic rvalid;
  logic rready;
  logic flush; // Drop all content
  modport user (output wdata, wvalid, rready, flush, input wready, rdata, rvalid);
  modport store (input wdata, wvalid, rready, flush, output wready, rdata, rvalid);
endinterface
`default_nettype wire

// ==== hpsr_fifo.sv ====
`timescale 1ns/10ps
`default_nettype none
module hpsr_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input wire logic mclk,
  input wire logic rst,
  hpsr_fifo_if.store f
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH]; // Storage
  logic [AW-1:0] wptr_r;
  logic [AW-1:0] rptr_r;
  logic [AW:0] count_r;
  logic [AW:0] count_nxt;
  logic wready_r; // Registered so the top sees a flop
  logic rvalid_r;
  logic push;
  logic pop;

  assign push = f.wvalid & wready_r & ~f.flush;
  assign pop = f.rready & rvalid_r & ~f.flush;
  assign f.wready = wready_r;
  assign f.rvalid = rvalid_r;
  assign f.rdata = mem_r[rptr_r];

  // Occupancy
  always_comb
  begin
    if (f.flush)
      count_nxt = '0;
    else
      count_nxt = count_r + (AW+1)'(push) - (AW+1)'(pop);
  end

  // Pointers and flags
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      wptr_r <= '0;
      rptr_r <= '0;
      count_r <= '0;
      wready_r <= 1'b1;
      rvalid_r <= 1'b0;
    end
    else
    begin
      count_r <= count_nxt;
      wready_r <= (count_nxt != (AW+1)'(DEPTH));
      rvalid_r <= (count_nxt != '0);
      if (f.flush)
      begin
        wptr_r <= '0;
        rptr_r <= '0;
      end
      else
      begin
        if (push)
          wptr_r <= wptr_r + 1'b1;
        if (pop)
          rptr_r <= rptr_r + 1'b1;
      end
    end
  end

  // Data array, no reset needed
  always_ff @(posedge mclk)
  begin
    if (push)
      mem_r[wptr_r] <= f.wdata;
  end
endmodule
`default_nettype wire

// ==== hpsr_top.sv ====
// Behaviour
// - Serial link 19200 baud, 8N1, no flow
// - First port with traffic becomes active
// - Other port ignored until 5 minutes idle or bus module removed
// - Service summary is unlatched masked OR
// - Summary query bit 6 shows service need
// - Event summary set from enabled event flags
// - Message available while response buffered
// - Event flag bit layout, bits 1,6 unused
// - Power-on flag set on every reset
// - Reading event flags returns then clears them
// - Event enable mask read/write, same layout
// - Clear status wipes flags, summary, error queue
// - Bus address 1 to 30, default 1
// - Version query answered only if module fitted
// - Summary bits 4,5,6; others zero
// - Summary read does not clear it
// - Zero service mask never requests service
// - Error groups set event flag bits
`timescale 1ns/10ps
`default_nettype none
`include "hpsr_map.svh"
module hpsr_top #(
  parameter int PRESCALE = `HPSR_PRESCALE,
  parameter int IDLE_TICKS = `HPSR_IDLE_TICKS
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic ser_rx_pin,
  output logic ser_tx_pin,
  input wire logic bus_fitted,
  input wire logic bus_rx_valid,
  input wire logic [7:0] bus_rx_data,
  output logic bus_tx_valid,
  output logic [7:0] bus_tx_data,
  input wire logic bus_tx_ready,
  input wire logic [7:0] bus_version,
  output logic rx_valid,
  output logic [7:0] rx_data,
  output logic rx_from_bus,
  input wire logic resp_valid,
  input wire logic [7:0] resp_data,
  output logic resp_ready,
  input wire logic cmd_valid,
  input var hpsr_pkg::hpsr_cmd_type cmd_code,
  input wire logic [7:0] cmd_data,
  output logic reply_valid,
  output logic [7:0] reply_data,
  output logic reply_refused,
  input wire logic op_complete,
  input wire logic err_command,
  input wire logic err_execution,
  input wire logic err_device,
  input wire logic err_query,
  output logic error_queue_clear,
  output logic service_request,
  output logic [4:0] bus_address,
  output var hpsr_pkg::hpsr_port_type active_port
);
  import hpsr_pkg::*;

  localparam logic [10:0] BIT_LAST = 11'(`HPSR_BIT_CYCLES - 1);
  localparam logic [10:0] BIT_HALF = 11'(`HPSR_BIT_CYCLES / 2);
  localparam logic [3:0] STOP_IDX = 4'(`HPSR_DATA_BITS + 1);
  localparam logic [23:0] PRE_LAST = 24'(PRESCALE - 1);
  localparam logic [23:0] IDLE_LAST = 24'(IDLE_TICKS - 1);

  // Summary byte builder, called only by the status path
  function automatic logic [7:0] hpsr_summary(input logic message_available_bit, input logic event_summary_bit,
                                               input logic [7:0] mask);
    logic [7:0] s;
    s = 8'h00;
    s[`HPSR_SB_MAV] = message_available_bit;
    s[`HPSR_SB_ESB] = event_summary_bit;
    s[`HPSR_SB_MSS] = |(s & mask);
    return s;
  endfunction

  hpsr_fifo_if #(.WIDTH(`HPSR_FIFO_WIDTH)) resp_q ();

  hpsr_fifo #(.WIDTH(`HPSR_FIFO_WIDTH), .DEPTH(`HPSR_FIFO_DEPTH)) u_resp_fifo (
    .mclk(mclk),
    .rst(rst),
    .f(resp_q)
  );

  logic [2:0] rx_sync_r; // Pin synchroniser, bit 0 first
  logic rx_lvl_r; // Filtered line level
  logic rx_busy_r;
  logic [10:0] rx_cnt_r;
  logic [3:0] rx_bit_r;
  logic [7:0] rx_sh_r;
  logic ser_byte_v_r; // Good frame pulse
  logic tx_busy_r;
  logic [10:0] tx_cnt_r;
  logic [3:0] tx_bit_r;
  logic [8:0] tx_sh_r;
  hpsr_port_type port_r;
  hpsr_port_type port_nxt;
  logic [23:0] pre_r; // Millisecond prescaler
  logic [23:0] idle_r; // Idle milliseconds
  logic idle_done;
  logic bus_hit;
  logic take_ser;
  logic take_bus;
  logic pop_ser;
  logic pop_bus;
  logic [7:0] flags_r;
  logic [7:0] enable_r;
  logic [7:0] mask_r;
  logic [7:0] set_vec; // Events of this cycle
  logic [7:0] summary;
  logic event_summary_bit;
  logic service_summary_bit;
  logic clear_cmd;
  logic addr_ok;

  assign resp_q.wdata = resp_data;
  assign resp_q.wvalid = resp_valid;
  assign resp_q.flush = clear_cmd;
  assign resp_ready = resp_q.wready;

  // Pin sync: level changes once second and third stages agree
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      rx_sync_r <= 3'h7;
      rx_lvl_r <= 1'b1;
    end
    else
    begin
      rx_sync_r <= {rx_sync_r[1:0], ser_rx_pin};
      if (rx_sync_r[1] == rx_sync_r[2])
        rx_lvl_r <= rx_sync_r[2];
    end
  end

  // Serial receiver, sampling mid-bit; bad stop drops the byte
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      rx_busy_r <= 1'b0;
      rx_cnt_r <= 11'h000;
      rx_bit_r <= 4'h0;
      rx_sh_r <= 8'h00;
      ser_byte_v_r <= 1'b0;
    end
    else
    begin
      ser_byte_v_r <= 1'b0;
      if (!rx_busy_r)
      begin
        if (!rx_lvl_r)
        begin
          rx_busy_r <= 1'b1;
          rx_cnt_r <= BIT_HALF;
          rx_bit_r <= 4'h0;
        end
      end
      else if (rx_cnt_r != 11'h000)
        rx_cnt_r <= rx_cnt_r - 11'h001;
      else
      begin
        rx_cnt_r <= BIT_LAST;
        rx_bit_r <= rx_bit_r + 4'h1;
        if (rx_bit_r == 4'h0)
        begin
          // Glitch, not a start bit
          if (rx_lvl_r)
            rx_busy_r <= 1'b0;
        end
        else if (rx_bit_r == STOP_IDX)
        begin
          rx_busy_r <= 1'b0;
          ser_byte_v_r <= rx_lvl_r;
        end
        else
          rx_sh_r <= {rx_lvl_r, rx_sh_r[7:1]};
      end
    end
  end

  // Who may deliver a byte now
  always_comb
  begin
    bus_hit = bus_rx_valid & bus_fitted;
    take_ser = ser_byte_v_r & (port_r != HPSR_PORT_BUS);
    take_bus = bus_hit & (port_r == HPSR_PORT_BUS |
                          (port_r == HPSR_PORT_NONE & ~ser_byte_v_r));
    idle_done = (pre_r == 24'h0) & (idle_r == IDLE_LAST) & (port_r != HPSR_PORT_NONE);
    port_nxt = port_r;
    unique case (port_r)
      HPSR_PORT_NONE:
        if (take_ser)
          port_nxt = HPSR_PORT_SER;
        else if (take_bus)
          port_nxt = HPSR_PORT_BUS;
      HPSR_PORT_SER:
        if (!take_ser && idle_done)
          port_nxt = HPSR_PORT_NONE;
      HPSR_PORT_BUS:
        // Module pulled out also frees the choice
        if ((!take_bus && idle_done) || !bus_fitted)
          port_nxt = HPSR_PORT_NONE;
      default:
        port_nxt = HPSR_PORT_NONE;
    endcase
  end

  // Active port state
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      port_r <= HPSR_PORT_NONE;
    else
      port_r <= port_nxt;
  end
  assign active_port = port_r;

  // Idle timer; a 1 ms prescaler keeps the counters to 24 bits
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      pre_r <= 24'h0;
      idle_r <= 24'h0;
    end
    else if (take_ser || take_bus)
    begin
      pre_r <= PRE_LAST;
      idle_r <= 24'h0;
    end
    else if (pre_r != 24'h0)
      pre_r <= pre_r - 24'h1;
    else
    begin
      pre_r <= PRE_LAST;
      if (port_r == HPSR_PORT_NONE || idle_done)
        idle_r <= 24'h0;
      else
        idle_r <= idle_r + 24'h1;
    end
  end

  // Accepted bytes toward the parser
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      rx_valid <= 1'b0;
      rx_data <= 8'h00;
      rx_from_bus <= 1'b0;
    end
    else
    begin
      rx_valid <= take_ser | take_bus;
      rx_data <= take_ser ? rx_sh_r : bus_rx_data;
      rx_from_bus <= take_bus;
    end
  end

  // Responses drain only to the active port; none active stalls
  assign pop_ser = (port_r == HPSR_PORT_SER) & ~tx_busy_r;
  assign pop_bus = (port_r == HPSR_PORT_BUS) & ~bus_tx_valid;
  assign resp_q.rready = pop_ser | pop_bus;

  // Serial transmitter, 8N1
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      tx_busy_r <= 1'b0;
      tx_cnt_r <= 11'h000;
      tx_bit_r <= 4'h0;
      tx_sh_r <= 9'h1ff;
      ser_tx_pin <= 1'b1;
    end
    else if (!tx_busy_r)
    begin
      if (resp_q.rvalid && pop_ser)
      begin
        tx_busy_r <= 1'b1;
        tx_cnt_r <= BIT_LAST;
        tx_bit_r <= 4'h0;
        tx_sh_r <= {1'b1, resp_q.rdata};
        ser_tx_pin <= 1'b0;
      end
    end
    else if (tx_cnt_r != 11'h000)
      tx_cnt_r <= tx_cnt_r - 11'h001;
    else if (tx_bit_r == STOP_IDX)
      tx_busy_r <= 1'b0;
    else
    begin
      tx_cnt_r <= BIT_LAST;
      tx_bit_r <= tx_bit_r + 4'h1;
      ser_tx_pin <= tx_sh_r[0];
      tx_sh_r <= {1'b1, tx_sh_r[8:1]};
    end
  end

  // Bus module byte out, valid held until taken
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      bus_tx_valid <= 1'b0;
      bus_tx_data <= 8'h00;
    end
    else if (bus_tx_valid)
    begin
      if (bus_tx_ready)
        bus_tx_valid <= 1'b0;
    end
    else if (resp_q.rvalid && pop_bus)
    begin
      bus_tx_valid <= 1'b1;
      bus_tx_data <= resp_q.rdata;
    end
  end

  // Event sources of this cycle
  always_comb
  begin
    clear_cmd = cmd_valid & (cmd_code == HPSR_CMD_CLEAR);
    addr_ok = (cmd_data >= `HPSR_ADDR_MIN) & (cmd_data <= `HPSR_ADDR_MAX);
    set_vec = 8'h00;
    set_vec[`HPSR_EV_OPC] = op_complete;
    set_vec[`HPSR_EV_QRY] = err_query;
    set_vec[`HPSR_EV_DEV] = err_device;
    // Out of range address counts as an execution fault
    set_vec[`HPSR_EV_EXE] = err_execution |
                            (cmd_valid & (cmd_code == HPSR_CMD_WR_ADDR) & ~addr_ok);
    set_vec[`HPSR_EV_CMD] = err_command;
  end

  // Event flags: a set in the clearing cycle survives
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      flags_r <= `HPSR_FLAGS_RST;
    else if (cmd_valid && (cmd_code == HPSR_CMD_RD_FLAGS || clear_cmd))
      flags_r <= set_vec;
    else
      flags_r <= flags_r | set_vec;
  end

  // Enable and service masks
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      enable_r <= 8'h00;
      mask_r <= 8'h00;
    end
    else if (cmd_valid)
    begin
      if (cmd_code == HPSR_CMD_WR_ENABLE)
        enable_r <= cmd_data;
      if (cmd_code == HPSR_CMD_WR_MASK)
        mask_r <= cmd_data;
    end
  end

  // Bus address, illegal values leave it unchanged
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      bus_address <= `HPSR_ADDR_RST;
    else if (cmd_valid && cmd_code == HPSR_CMD_WR_ADDR && addr_ok)
      bus_address <= cmd_data[4:0];
  end

  // Summary is pure logic; reading has no side effect
  assign event_summary_bit = |(flags_r & enable_r);
  assign summary = hpsr_summary(resp_q.rvalid, event_summary_bit, mask_r);
  assign service_summary_bit = summary[`HPSR_SB_MSS];

  // Request line toward the bus module
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      service_request <= 1'b0;
    else
      service_request <= service_summary_bit;
  end

  // Query answers
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      reply_valid <= 1'b0;
      reply_data <= 8'h00;
      reply_refused <= 1'b0;
      error_queue_clear <= 1'b0;
    end
    else
    begin
      reply_valid <= 1'b0;
      reply_refused <= 1'b0;
      error_queue_clear <= clear_cmd;
      if (cmd_valid)
      begin
        unique case (cmd_code)
          HPSR_CMD_RD_FLAGS:
          begin
            reply_valid <= 1'b1;
            reply_data <= flags_r;
          end
          HPSR_CMD_RD_ENABLE:
          begin
            reply_valid <= 1'b1;
            reply_data <= enable_r;
          end
          HPSR_CMD_RD_MASK:
          begin
            reply_valid <= 1'b1;
            reply_data <= mask_r;
          end
          HPSR_CMD_RD_SUMMARY:
          begin
            reply_valid <= 1'b1;
            reply_data <= summary;
          end
          HPSR_CMD_RD_ADDR:
          begin
            reply_valid <= 1'b1;
            reply_data <= {3'h0, bus_address};
          end
          HPSR_CMD_RD_VERSION:
            if (bus_fitted)
            begin
              reply_valid <= 1'b1;
              reply_data <= bus_version;
            end
            else
              reply_refused <= 1'b1;
          default:
            reply_valid <= 1'b0;
        endcase
      end
    end
  end

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  property p_pon;
    $fell(rst) |-> flags_r[`HPSR_EV_PON];
  endproperty
  a_pon: assert property (p_pon) else $error("power-on flag missing");

  property p_unused;
    (flags_r & `HPSR_EV_UNUSED_MASK) == 8'h00;
  endproperty
  a_unused: assert property (p_unused) else $error("unused flag set");

  property p_rd_clear;
    cmd_valid && cmd_code == HPSR_CMD_RD_FLAGS && set_vec == 8'h00
      |=> flags_r == 8'h00 && reply_valid && reply_data == $past(flags_r);
  endproperty
  a_rd_clear: assert property (p_rd_clear) else $error("flag read wrong");

  property p_clear;
    clear_cmd && set_vec == 8'h00 |=> flags_r == 8'h00 && !resp_q.rvalid && error_queue_clear;
  endproperty
  a_clear: assert property (p_clear) else $error("clear status incomplete");

  property p_esb;
    cmd_valid && cmd_code == HPSR_CMD_RD_SUMMARY |=> reply_data[`HPSR_SB_ESB] == $past(event_summary_bit);
  endproperty
  a_esb: assert property (p_esb) else $error("event summary wrong");

  property p_mss;
    cmd_valid && cmd_code == HPSR_CMD_RD_SUMMARY |=> reply_data[`HPSR_SB_MSS] == $past(service_summary_bit)
      && reply_data[3:0] == 4'h0 && !reply_data[7];
  endproperty
  a_mss: assert property (p_mss) else $error("service summary wrong");

  property p_no_srq;
    mask_r == 8'h00 [*2] |-> !service_request;
  endproperty
  a_no_srq: assert property (p_no_srq) else $error("request with zero mask");

  property p_mav;
    resp_valid && resp_ready && !clear_cmd |=> summary[`HPSR_SB_MAV];
  endproperty
  a_mav: assert property (p_mav) else $error("message available missing");

  property p_addr;
    cmd_valid && cmd_code == HPSR_CMD_WR_ADDR && !addr_ok |=> $stable(bus_address);
  endproperty
  a_addr: assert property (p_addr) else $error("bad address taken");

  property p_lock;
    port_r == HPSR_PORT_SER && bus_hit && !idle_done |=> port_r == HPSR_PORT_SER && !rx_from_bus;
  endproperty
  a_lock: assert property (p_lock) else $error("other port stole link");

  property p_first;
    port_r == HPSR_PORT_NONE && ser_byte_v_r |=> port_r == HPSR_PORT_SER && rx_valid;
  endproperty
  a_first: assert property (p_first) else $error("first port not taken");

  property p_version;
    cmd_valid && cmd_code == HPSR_CMD_RD_VERSION && !bus_fitted |=> reply_refused && !reply_valid;
  endproperty
  a_version: assert property (p_version) else $error("version answered unfitted");

  c_ser_active: cover property (port_r == HPSR_PORT_NONE ##1 port_r == HPSR_PORT_SER);
  c_bus_active: cover property (port_r == HPSR_PORT_NONE ##1 port_r == HPSR_PORT_BUS);
  c_srq: cover property ($rose(service_request));
  c_full: cover property (!resp_ready);
endmodule
`default_nettype wire

// ==== hpsr_host_model.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "hpsr_map.svh"
// Remote host stand-in: serial terminal plus bus module
module hpsr_host_model (
  input wire logic mclk,
  input wire logic ser_tx_pin,
  output logic ser_rx_pin,
  output logic bus_rx_valid,
  output logic [7:0] bus_rx_data,
  input wire logic bus_tx_valid,
  input wire logic [7:0] bus_tx_data,
  output logic bus_tx_ready
);
  localparam int BIT = `HPSR_BIT_CYCLES; // Cycles per bit
  // Idle line high, bus quiet
  initial
  begin
    ser_rx_pin = 1'b1;
    bus_rx_valid = 1'b0;
    bus_rx_data = 8'h00;
    bus_tx_ready = 1'b0;
  end
  // Start, 8 data LSB first, one stop, no parity
  task automatic ser_send(input logic [7:0] b);
    logic [9:0] frame;
    frame = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++)
    begin
      ser_rx_pin = frame[i];
      repeat (BIT) @(posedge mclk);
      #1;
    end
  endtask
  // Sample mid-bit; a bad stop bit fails
  task automatic ser_get(output logic [7:0] b, output logic ok);
    int n;
    for (n = 0; n < 5000 && ser_tx_pin !== 1'b0; n++) @(posedge mclk) #1;
    repeat (BIT / 2) @(posedge mclk);
    for (int i = 0; i < 8; i++)
    begin
      repeat (BIT) @(posedge mclk);
      b[i] = ser_tx_pin;
    end
    repeat (BIT) @(posedge mclk);
    ok = (n < 5000) && ser_tx_pin === 1'b1;
  endtask
  // One-cycle byte; data inverted after so stale value never matches
  task automatic bus_send(input logic [7:0] b);
    @(posedge mclk) #1;
    bus_rx_valid = 1'b1;
    bus_rx_data = b;
    @(posedge mclk) #1;
    bus_rx_valid = 1'b0;
    bus_rx_data = ~b;
  endtask
  // Slow taker: stalls three cycles, byte must hold meanwhile
  task automatic bus_take(output logic [7:0] b, output logic ok);
    int n;
    logic [7:0] first;
    for (n = 0; n < 200 && bus_tx_valid !== 1'b1; n++) @(posedge mclk) #1;
    first = bus_tx_data;
    repeat (3) @(posedge mclk);
    #1;
    ok = (n < 200) && bus_tx_valid === 1'b1 && bus_tx_data === first;
    bus_tx_ready = 1'b1;
    @(posedge mclk);
    b = bus_tx_data;
    #1;
    bus_tx_ready = 1'b0;
  endtask
endmodule
`default_nettype wire

// ==== host_port_status_reporting_bench.sv ====
`timescale 1ns/10ps
`default_nettype none
module host_port_status_reporting_bench;
  import hpsr_pkg::*;
  logic mclk, rst, ser_rx_pin, ser_tx_pin, bus_fitted, bus_rx_valid, bus_tx_valid, bus_tx_ready;
  logic [7:0] bus_rx_data, bus_tx_data, bus_version, rx_data, resp_data, cmd_data, reply_data;
  logic rx_valid, rx_from_bus, resp_valid, resp_ready, cmd_valid, reply_valid, reply_refused;
  logic error_queue_clear, service_request, ok, last_bus, seen;
  logic [4:0] ev; // Event pulses, opc/query/device/exec/command
  logic [4:0] bus_address;
  logic [7:0] last_rx, b;
  hpsr_cmd_type cmd_code;
  hpsr_port_type active_port;
  int mismatches, total_checks, rx_count, n;
  int pos[5] = '{0, 2, 3, 4, 5}; // Flag bit of each event source
  // Short idle release: 4 x 5000 = 20000 cycles
  hpsr_top #(.PRESCALE(4), .IDLE_TICKS(5000)) dut (.mclk(mclk), .rst(rst),
    .ser_rx_pin(ser_rx_pin), .ser_tx_pin(ser_tx_pin), .bus_fitted(bus_fitted),
    .bus_rx_valid(bus_rx_valid), .bus_rx_data(bus_rx_data), .bus_tx_valid(bus_tx_valid),
    .bus_tx_data(bus_tx_data), .bus_tx_ready(bus_tx_ready), .bus_version(bus_version),
    .rx_valid(rx_valid), .rx_data(rx_data), .rx_from_bus(rx_from_bus),
    .resp_valid(resp_valid), .resp_data(resp_data), .resp_ready(resp_ready),
    .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_data(cmd_data),
    .reply_valid(reply_valid), .reply_data(reply_data), .reply_refused(reply_refused),
    .op_complete(ev[0]), .err_query(ev[1]), .err_device(ev[2]), .err_execution(ev[3]),
    .err_command(ev[4]), .error_queue_clear(error_queue_clear),
    .service_request(service_request), .bus_address(bus_address), .active_port(active_port));
  hpsr_host_model host (.mclk(mclk), .ser_tx_pin(ser_tx_pin), .ser_rx_pin(ser_rx_pin),
    .bus_rx_valid(bus_rx_valid), .bus_rx_data(bus_rx_data), .bus_tx_valid(bus_tx_valid),
    .bus_tx_data(bus_tx_data), .bus_tx_ready(bus_tx_ready));
  // Clock, 50 ns period
  initial
  begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  // Received byte log; pulse lasts one cycle
  always @(posedge mclk)
    if (rx_valid === 1'b1)
    begin
      rx_count++;
      last_rx = rx_data;
      last_bus = rx_from_bus;
    end
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input string name, input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic timeout();
    mismatches++;
    $display("[ERR] wait expected done seen timeout");
    print_verdict();
  endtask
  // Command strobe for one cycle; answer lands the cycle after
  task automatic cmd(input hpsr_cmd_type c, input logic [7:0] d);
    @(posedge mclk) #1;
    cmd_valid = 1'b1;
    cmd_code = c;
    cmd_data = d;
    @(posedge mclk) #1;
    cmd_valid = 1'b0;
  endtask
  task automatic query(input hpsr_cmd_type c, input string name, input logic [7:0] exp);
    cmd(c, 8'h00);
    chk({name, " strobe"}, {7'h00, reply_valid}, 8'h01);
    chk(name, reply_data, exp);
  endtask
  task automatic pulse(input logic [4:0] v);
    @(posedge mclk) #1;
    ev = v;
    @(posedge mclk) #1;
    ev = 5'h00;
  endtask
  // Offer one response byte, held until taken
  task automatic push(input logic [7:0] d);
    int k;
    k = 0;
    @(posedge mclk) #1;
    resp_valid = 1'b1;
    resp_data = d;
    do
    begin
      @(posedge mclk);
      k++;
    end
    while (resp_ready !== 1'b1 && k < 50);
    #1;
    resp_valid = 1'b0;
    if (k >= 50)
      timeout();
  endtask
  task automatic wait_rx(input int n0);
    int k;
    for (k = 0; k < 20000 && rx_count == n0; k++) @(posedge mclk) #1;
    if (k >= 20000)
      timeout();
  endtask
  // Main sequence
  initial
  begin
    rst = 1'b1;
    bus_fitted = 1'b0;
    bus_version = 8'h37;
    resp_valid = 1'b0;
    resp_data = 8'h00;
    cmd_valid = 1'b0;
    cmd_code = HPSR_CMD_NOP;
    cmd_data = 8'h00;
    ev = 5'h00;
    repeat (12) @(posedge mclk);
    #1;
    rst = 1'b0;
    query(HPSR_CMD_RD_FLAGS, "flags", 8'h80);
    query(HPSR_CMD_RD_FLAGS, "flags", 8'h00);
    query(HPSR_CMD_RD_ENABLE, "enable", 8'h00);
    query(HPSR_CMD_RD_MASK, "mask", 8'h00);
    query(HPSR_CMD_RD_ADDR, "addr", 8'h01);
    query(HPSR_CMD_RD_SUMMARY, "summary", 8'h00);
    for (int i = 0; i < 5; i++)
    begin
      pulse(5'h01 << i);
      query(HPSR_CMD_RD_FLAGS, "flags", 8'h01 << pos[i]);
    end
    // Only enabled events reach the summary
    pulse(5'h1e);
    cmd(HPSR_CMD_WR_ENABLE, 8'h01);
    query(HPSR_CMD_RD_ENABLE, "enable", 8'h01);
    query(HPSR_CMD_RD_SUMMARY, "summary", 8'h00);
    pulse(5'h01);
    query(HPSR_CMD_RD_SUMMARY, "summary", 8'h20);
    query(HPSR_CMD_RD_SUMMARY, "summary", 8'h20);
    chk("service", {7'h00, service_request}, 8'h00);
    cmd(HPSR_CMD_WR_MASK, 8'h20);
    repeat (2) @(posedge mclk);
    #1;
    chk("service", {7'h00, service_request}, 8'h01);
    query(HPSR_CMD_RD_SUMMARY, "summary", 8'h60);
    query(HPSR_CMD_RD_FLAGS, "flags", 8'h3d);
    query(HPSR_CMD_RD_SUMMARY, "summary", 8'h00);
    // Address range, upper end and just outside both ends
    cmd(HPSR_CMD_WR_ADDR, 8'h1b);
    query(HPSR_CMD_RD_ADDR, "addr", 8'h1b);
    cmd(HPSR_CMD_WR_ADDR, 8'h1f);
    cmd(HPSR_CMD_WR_ADDR, 8'h00);
    query(HPSR_CMD_RD_ADDR, "addr", 8'h1b);
    query(HPSR_CMD_RD_FLAGS, "flags", 8'h10);
    cmd(HPSR_CMD_WR_ADDR, 8'h1e);
    chk("address pin", {3'h0, bus_address}, 8'h1e);
    cmd(HPSR_CMD_RD_VERSION, 8'h00);
    chk("refused", {7'h00, reply_refused}, 8'h01);
    bus_fitted = 1'b1;
    query(HPSR_CMD_RD_VERSION, "version", 8'h37);
    // No port active: buffer fills until it refuses
    for (int i = 0; i < 32; i++)
      push(i[7:0]);
    @(posedge mclk) #1;
    chk("resp_ready", {7'h00, resp_ready}, 8'h00);
    query(HPSR_CMD_RD_SUMMARY, "summary", 8'h10);
    pulse(5'h10);
    cmd(HPSR_CMD_CLEAR, 8'h00);
    seen = error_queue_clear;
    @(posedge mclk) #1;
    seen = seen | error_queue_clear;
    chk("queue clear", {7'h00, seen}, 8'h01);
    query(HPSR_CMD_RD_SUMMARY, "summary", 8'h00);
    query(HPSR_CMD_RD_FLAGS, "flags", 8'h00);
    chk("resp_ready", {7'h00, resp_ready}, 8'h01);
    // Bus port claims first; serial then ignored
    n = rx_count;
    host.bus_send(8'h4e);
    wait_rx(n);
    chk("rx", last_rx, 8'h4e);
    chk("from bus", {7'h00, last_bus}, 8'h01);
    chk("port", {5'h00, active_port}, {5'h00, HPSR_PORT_BUS});
    n = rx_count;
    host.ser_send(8'ha5);
    repeat (10) @(posedge mclk);
    chk("dropped", 8'(rx_count - n), 8'h00);
    chk("port", {5'h00, active_port}, {5'h00, HPSR_PORT_BUS});
    push(8'h5a);
    host.bus_take(b, ok);
    chk("bus tx", b, 8'h5a);
    chk("bus hold", {7'h00, ok}, 8'h01);
    for (n = 0; n < 30000 && active_port !== HPSR_PORT_NONE; n++) @(posedge mclk) #1;
    if (n >= 30000)
      timeout();
    chk("port", {5'h00, active_port}, {5'h00, HPSR_PORT_NONE});
    // Serial takes over after idle release
    n = rx_count;
    host.ser_send(8'hc3);
    wait_rx(n);
    chk("rx", last_rx, 8'hc3);
    chk("from bus", {7'h00, last_bus}, 8'h00);
    chk("port", {5'h00, active_port}, {5'h00, HPSR_PORT_SER});
    // Bus byte while serial holds the link is dropped
    n = rx_count;
    host.bus_send(8'h3c);
    repeat (2) @(posedge mclk);
    chk("dropped", 8'(rx_count - n), 8'h00);
    chk("port", {5'h00, active_port}, {5'h00, HPSR_PORT_SER});
    push(8'h96);
    host.ser_get(b, ok);
    chk("ser tx", b, 8'h96);
    chk("stop bit", {7'h00, ok}, 8'h01);
    print_verdict();
  end
endmodule
`default_nettype wire
